// ==== bench/lulk_far.sv ====
// far-side model: address translation and memory
// assumes requests held until the ack edge, acks one cycle long
`timescale 1ns/1ps
module lulk_far #(
  parameter logic [63:0] MEMV = 64'h0,
  parameter logic [63:0] OFS  = 64'h0,
  parameter logic [2:0]  ATTR = 3'h0
) (
  // clock
  input  wire logic        clk,
  // translation
  input  wire logic        xlat_req,
  input  wire logic [63:0] virtual_addr,
  output logic             xlat_ack,
  output logic      [2:0]  xlat_fault,
  output logic      [2:0]  cacheability_attribute,
  output logic      [63:0] phys_addr,
  // memory
  input  wire logic        mem_req,
  output logic             mem_ack,
  output logic             mem_err,
  output logic      [63:0] mem_data,
  // scenario control
  input  wire logic [2:0]  fault_sel,
  input  wire logic        err_sel,
  input  wire logic        slow
);
  logic [1:0] wait_ff = 2'h0;
  initial begin
    xlat_ack = 1'b0;
    mem_ack = 1'b0;
    phys_addr = 64'h0;
    mem_data = 64'h0;
  end
  // data lines churn outside an answer
  always @(posedge clk) begin
    xlat_ack  <= 1'b0;
    mem_ack   <= 1'b0;
    phys_addr <= ~phys_addr;
    mem_data  <= ~mem_data;
    if ((xlat_req && !xlat_ack) || (mem_req && !mem_ack)) begin
      wait_ff <= wait_ff + 2'h1;
      if (!slow || wait_ff == 2'h3) begin
        wait_ff <= 2'h0;
        if (xlat_req) begin
          xlat_ack   <= 1'b1;
          phys_addr  <= virtual_addr + OFS;
          xlat_fault <= fault_sel;
          cacheability_attribute <= ATTR;
        end else begin
          mem_ack  <= 1'b1;
          mem_data <= MEMV;
          mem_err  <= err_sel;
        end
      end
    end
  end
endmodule // lulk_far

// ==== bench/lulk_unit_tb.sv ====
// testbench for the load unit with a far-side model
// assumes one core clock, inputs driven at the falling edge
`timescale 1ns/1ps
module lulk_unit_tb;
  localparam logic [63:0] MEMV = 64'h8070F0E12C3B4A59;
  localparam logic [63:0] OFS  = 64'h10000;
  localparam logic [63:0] OLD  = 64'hA1B2C3D4E5F60718;
  localparam logic [2:0]  ATTR = 3'h5;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, user_order_swap = 1'b1;
  logic core_byte_order_big = 1'b0, float_usable = 1'b1, slow = 1'b0;
  logic op_reserved = 1'b0, watch_hit = 1'b0, err_sel = 1'b0;
  logic cond_store = 1'b0, link_break = 1'b0;
  logic [2:0]  req_op = 3'h0, fault_sel = 3'h0;
  logic [63:0] base_val = 64'h0, index_val = 64'h0, old_dest = OLD;
  logic [15:0] offset = 16'h0;
  logic [4:0]  dest_sel = 5'h0, wb_sel;
  logic [2:0]  xlat_fault, cacheability_attribute, mem_attr, exc_code;
  logic [63:0] virtual_addr, phys_addr, mem_addr, mem_data, wb_data;
  logic xlat_req, xlat_ack, mem_req, mem_ack, mem_err, busy, cond_ok;
  logic wb_gpr, wb_float_register, exc_valid, link_flag;
  int   err_count = 0, compares = 0;
  lulk_unit DUT (.*);
  lulk_far #(.MEMV(MEMV), .OFS(OFS), .ATTR(ATTR)) far (.*);
  always #2 clk = ~clk;
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [2:0] op, input logic [63:0] b, x,
                      input logic [15:0] o, input logic bg,
                      input logic [2:0] ec);
    logic [63:0] ea, m, d, w;
    logic [2:0]  y;
    logic        hit, sm;
    int          i;
    ea = (op == 3'h1) ? b + x : b + {{48{o[15]}}, o};
    y = ea[2:0] ^ {bg, bg & (op != 3'h4), bg & (op == 3'h0)};
    m = ~64'h0 >> (8 * y);
    d = (op == 3'h0) ? (OLD & ~m) | (MEMV >> (8 * y)) :
        (op == 3'h2) ? {{48{MEMV[8*y+15]}}, MEMV[8*y+:16]} :
        (op == 3'h3) ? {48'h0, MEMV[8*y+:16]} :
        (op == 3'h4) ? {{32{MEMV[8*y+31]}}, MEMV[8*y+:32]} : MEMV;
    w = (ec != 3'h0) ? 64'h1 : (op == 3'h1) ? 64'h2 : 64'h4;
    hit = 1'b0;
    sm = 1'b0;
    @(negedge clk);
    req_op = op;
    base_val = b;
    index_val = x;
    offset = o;
    core_byte_order_big = bg;
    dest_sel = 5'(op) + 5'h9;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 40 && !hit; i++) begin
      @(posedge clk);
      #1;
      if (xlat_req) check(virtual_addr, ea);
      if (mem_req) begin
        sm = 1'b1;
        check(mem_addr, (ea + OFS) & ~64'h7);
        check(64'(mem_attr), 64'(ATTR));
      end
      hit = wb_gpr | wb_float_register | exc_valid;
    end
    if (!hit) begin
      err_count++;
      conclude();
    end
    check(64'({wb_gpr, wb_float_register, exc_valid}), w);
    if (ec == 3'h0) begin
      check(wb_data, d);
      check(64'(wb_sel), 64'(dest_sel));
    end else begin
      check(64'(exc_code), 64'(ec));
      if (ec == 3'h1) check(64'(sm), 64'h0);
    end
    for (i = 0; i < 8 && busy; i++) @(posedge clk);
    check(64'(busy), 64'h0);
    if (busy) conclude();
  endtask
  task automatic ev(input logic cs, input logic lb, input logic ok);
    @(negedge clk);
    cond_store = cs;
    link_break = lb;
    @(negedge clk);
    cond_store = 1'b0;
    link_break = 1'b0;
    if (cs) check(64'({cond_ok, link_flag}), 64'({ok, 1'b0}));
    else check(64'(link_flag), 64'h0);
  endtask
  task automatic t_right();
    for (int k = 0; k < 16; k++) load(3'h0, 64'h4000 + 64'(k[2:0]),
                                      64'h0, 16'hFFF0, k[3], 3'h0);
    $display("test right part done");
  endtask
  task automatic t_half();
    for (int k = 0; k < 16; k++) load(3'h2 + 3'(k[0]),
      64'h100 + 64'({k[2:1], 1'b0}), 64'h0, 16'h0, k[3], 3'h0);
    load(3'h2, 64'h101, 64'h0, 16'h0, 1'b0, 3'h1);
    load(3'h3, 64'h108, 64'h0, 16'hFFFF, 1'b1, 3'h1);
    $display("test half done");
  endtask
  task automatic t_wide();
    for (int k = 0; k < 4; k++) load(3'h4, 64'h200 + 64'({k[0], 2'b0}),
                                     64'h0, 16'h0, k[1], 3'h0);
    load(3'h4, 64'h202, 64'h0, 16'h0, 1'b0, 3'h1);
    load(3'h5, 64'h300, 64'h0, 16'h8, 1'b0, 3'h0);
    load(3'h5, 64'h300, 64'h0, 16'h4, 1'b0, 3'h1);
    load(3'h1, 64'h400, 64'h18, 16'h0, 1'b0, 3'h0);
    load(3'h1, 64'h400, 64'h1C, 16'h0, 1'b0, 3'h1);
    @(negedge clk) float_usable = 1'b0;
    load(3'h1, 64'h400, 64'h18, 16'h0, 1'b0, 3'h4);
    @(negedge clk) float_usable = 1'b1;
    $display("test wide done");
  endtask
  task automatic t_fault();
    @(negedge clk) op_reserved = 1'b1;
    load(3'h2, 64'h500, 64'h0, 16'h0, 1'b0, 3'h5);
    @(negedge clk) op_reserved = 1'b0;
    watch_hit = 1'b1;
    load(3'h4, 64'h500, 64'h0, 16'h0, 1'b0, 3'h6);
    @(negedge clk) watch_hit = 1'b0;
    slow = 1'b1;
    for (int k = 2; k < 4; k++) begin
      @(negedge clk) fault_sel = 3'(k);
      load(3'h5, 64'h500, 64'h0, 16'h0, 1'b0, 3'(k));
    end
    @(negedge clk) fault_sel = 3'h0;
    err_sel = 1'b1;
    load(3'h3, 64'h500, 64'h0, 16'h0, 1'b0, 3'h7);
    @(negedge clk) err_sel = 1'b0;
    slow = 1'b0;
    $display("test faults done");
  endtask
  task automatic t_link();
    load(3'h4, 64'h600, 64'h0, 16'h0, 1'b0, 3'h0);
    check(64'(link_flag), 64'h1);
    ev(1'b1, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    load(3'h5, 64'h600, 64'h0, 16'h0, 1'b0, 3'h0);
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b0);
    load(3'h5, 64'h600, 64'h0, 16'h0, 1'b0, 3'h0);
    load(3'h2, 64'h600, 64'h0, 16'h0, 1'b0, 3'h0);
    check(64'(link_flag), 64'h1);
    load(3'h4, 64'h604, 64'h0, 16'h0, 1'b0, 3'h0);
    check(64'(link_flag), 64'h1);
    ev(1'b1, 1'b0, 1'b1);
    $display("test link done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_right();
    t_half();
    t_wide();
    t_fault();
    t_link();
    conclude();
  end
endmodule // lulk_unit_tb

// ==== hw/lulk_lane.sv ====
// byte lane selection and extension of loaded doubleword
// assumes combinational use inside the load unit
`timescale 1ns/1ps
`include "lulk_params.svh"
module lulk_lane
  import lulk_pkg::*;
(
  // request
  input  wire logic [2:0]  op,
  input  wire logic [2:0]  low_addr,
  input  wire logic        core_byte_order_big,
  input  wire logic [63:0] mem_data,
  input  wire logic [63:0] old_dest,
  // result
  output logic      [63:0] result
);
  logic [2:0]  hsel;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic [15:0] half;
  logic [31:0] word;
  logic [63:0] merged;
  logic [63:0] shifted;
  logic [63:0] keep_mask;

  always_comb begin
    hsel = low_addr ^ {core_byte_order_big, core_byte_order_big, 1'b0};
    wsel = low_addr ^ {core_byte_order_big, 2'h0};
    rsel = low_addr ^ {3{core_byte_order_big}};
    half = mem_data[{hsel, 3'h0} +: 16];
    word = mem_data[{wsel, 3'h0} +: 32];
    // right part: memory bytes shifted down, upper dest bytes kept
    shifted = mem_data >> {rsel, 3'h0};
    keep_mask = ~(64'hFFFFFFFFFFFFFFFF >> {rsel, 3'h0});
    merged = (old_dest & keep_mask) | shifted;
    case (op)
      `LULK_OP_RIGHT:  result = merged;
      `LULK_OP_HALF_S: result = {{48{half[15]}}, half};
      `LULK_OP_HALF_U: result = {48'h0, half};
      `LULK_OP_LL_W:   result = {{32{word[31]}}, word};
      default:         result = mem_data;
    endcase
  end
endmodule // lulk_lane

// ==== hw/lulk_params.svh ====
// load unit constants: opcodes, exception codes, alignment masks
// assumes inclusion by the package and the load unit modules
`ifndef LULK_PARAMS_SVH
`define LULK_PARAMS_SVH
`define LULK_OP_RIGHT   3'h0
`define LULK_OP_FIDX    3'h1
`define LULK_OP_HALF_S  3'h2
`define LULK_OP_HALF_U  3'h3
`define LULK_OP_LL_W    3'h4
`define LULK_OP_LL_D    3'h5
`define LULK_EXC_NONE   3'h0
`define LULK_EXC_ADDR   3'h1
`define LULK_EXC_REFILL 3'h2
`define LULK_EXC_INVAL  3'h3
`define LULK_EXC_CPU    3'h4
`define LULK_EXC_RSVD   3'h5
`define LULK_EXC_WATCH  3'h6
`define LULK_EXC_BUS    3'h7
`define LULK_MASK_HALF  3'h1
`define LULK_MASK_WORD  3'h3
`define LULK_MASK_DBL   3'h7
`endif

// ==== hw/lulk_pkg.sv ====
// load unit types
// assumes lulk_params.svh in the include path
`include "lulk_params.svh"
package lulk_pkg;
  typedef enum logic [5:0] {
    LULK_IDLE = 6'h01,
    LULK_XLAT = 6'h02,
    LULK_MEM  = 6'h04,
    LULK_DONE = 6'h08,
    LULK_FAIL = 6'h10
  } lulk_state_t;
endpackage

// ==== hw/lulk_unit.sv ====
// load unit for right-part, indexed float, half and linked loads
// assumes translation and memory answer with one-cycle pulses
`timescale 1ns/1ps
`include "lulk_params.svh"

// Function
// - right load keeps upper bytes, merges lower
// - indexed float load adds two registers
// - indexed float load faults unless 8-aligned
// - indexed float load may report coprocessor unusable
// - offset loads sign-extend sixteen bit displacement
// - signed half load sign-extends halfword
// - unsigned half load zero-extends halfword
// - half loads fault on odd address
// - linked word sign-extends aligned word
// - linked word faults unless 4-aligned
// - linked load sets link flag
// - one sequence; new linked load replaces
// - conditional store ends sequence, success if atomic
// - other processors' links do not clear ours
// - sequence may be abandoned without store
// - linked double loads doubleword unmodified
// - linked double faults unless 8-aligned
module lulk_unit
  import lulk_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // pipeline request
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_op,
  input  wire logic [63:0] base_val,
  input  wire logic [63:0] index_val,
  input  wire logic [15:0] offset,
  input  wire logic [63:0] old_dest,
  input  wire logic [4:0]  dest_sel,
  input  wire logic        core_byte_order_big,
  input  wire logic        user_order_swap,
  input  wire logic        float_usable,
  input  wire logic        op_reserved,
  input  wire logic        watch_hit,
  // conditional store and coherence events
  input  wire logic        cond_store,
  input  wire logic        link_break,
  // translation
  output logic             xlat_req,
  output logic      [63:0] virtual_addr,
  input  wire logic        xlat_ack,
  input  wire logic [2:0]  xlat_fault,
  input  wire logic [2:0]  cacheability_attribute,
  input  wire logic [63:0] phys_addr,
  // memory
  output logic             mem_req,
  output logic      [63:0] mem_addr,
  output logic      [2:0]  mem_attr,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [63:0] mem_data,
  // writeback
  output logic             wb_gpr,
  output logic             wb_float_register,
  output logic      [4:0]  wb_sel,
  output logic      [63:0] wb_data,
  output logic             exc_valid,
  output logic      [2:0]  exc_code,
  output logic             busy,
  output logic             link_flag,
  output logic             cond_ok
);
  typedef struct packed {
    lulk_state_t st;
    logic [2:0]  op;
    logic [63:0] va;
    logic [63:0] pa;
    logic [2:0]  attr;
    logic [63:0] old;
    logic [4:0]  sel;
    logic        big;
    logic        swap;
    logic        xreq;
    logic        mreq;
    logic        wg;
    logic        wf;
    logic [63:0] data;
    logic        exc;
    logic [2:0]  code;
    logic        link;
    logic        ok;
    logic        bsy;
  } lulk_regs_t;

  lulk_regs_t r_ff;
  lulk_regs_t nxt_r;
  logic [63:0] ea;
  logic [2:0]  amask;
  logic [2:0]  early;
  logic [63:0] lane_out;
  logic        take;
  logic [2:0]  ofs_low;
  logic [2:0]  idx_low;
  logic [63:0] ofs_ext;

  function automatic logic [2:0] align_mask(input logic [2:0] op);
    case (op)
      `LULK_OP_HALF_S, `LULK_OP_HALF_U: align_mask = `LULK_MASK_HALF;
      `LULK_OP_LL_W:                    align_mask = `LULK_MASK_WORD;
      `LULK_OP_FIDX, `LULK_OP_LL_D:     align_mask = `LULK_MASK_DBL;
      default:                          align_mask = 3'h0;
    endcase
  endfunction

  lulk_lane u_lane (
    .op                  (r_ff.op),
    .low_addr            (r_ff.va[2:0]),
    .core_byte_order_big (r_ff.big),
    .mem_data            (mem_data),
    .old_dest            (r_ff.old),
    .result              (lane_out)
  );

  always_comb begin
    nxt_r = r_ff;
    nxt_r.wg = 1'b0;
    nxt_r.wf = 1'b0;
    nxt_r.exc = 1'b0;
    nxt_r.xreq = 1'b0;
    nxt_r.mreq = 1'b0;
    ea = (req_op == `LULK_OP_FIDX) ? base_val + index_val
       : base_val + {{48{offset[15]}}, offset};
    amask = align_mask(req_op);
    early = `LULK_EXC_NONE;
    if (op_reserved) begin
      early = `LULK_EXC_RSVD;
    end else if (req_op == `LULK_OP_FIDX && !float_usable) begin
      early = `LULK_EXC_CPU;
    end else if ((ea[2:0] & amask) != 3'h0) begin
      early = `LULK_EXC_ADDR;
    end else if (watch_hit) begin
      early = `LULK_EXC_WATCH;
    end
    // conditional store ends the sequence; otherwise link_break clears it
    if (cond_store) begin
      nxt_r.ok = r_ff.link;
      nxt_r.link = 1'b0;
    end else if (link_break) begin
      nxt_r.link = 1'b0;
    end
    case (r_ff.st)
      LULK_IDLE: begin
        if (req_valid) begin
          nxt_r.op = req_op;
          nxt_r.va = ea;
          nxt_r.old = old_dest;
          nxt_r.sel = dest_sel;
          nxt_r.big = core_byte_order_big;
          nxt_r.swap = user_order_swap;
          if (early != `LULK_EXC_NONE) begin
            nxt_r.code = early;
            nxt_r.st = LULK_FAIL;
          end else begin
            nxt_r.xreq = 1'b1;
            nxt_r.st = LULK_XLAT;
          end
        end
      end
      LULK_XLAT: begin
        nxt_r.xreq = !xlat_ack;
        if (xlat_ack) begin
          if (xlat_fault != `LULK_EXC_NONE) begin
            nxt_r.code = xlat_fault;
            nxt_r.st = LULK_FAIL;
          end else begin
            nxt_r.pa = phys_addr;
            nxt_r.attr = cacheability_attribute;
            nxt_r.mreq = 1'b1;
            nxt_r.st = LULK_MEM;
          end
        end
      end
      LULK_MEM: begin
        nxt_r.mreq = !mem_ack;
        if (mem_ack) begin
          if (mem_err) begin
            nxt_r.code = `LULK_EXC_BUS;
            nxt_r.st = LULK_FAIL;
          end else begin
            nxt_r.data = lane_out;
            nxt_r.wf = (r_ff.op == `LULK_OP_FIDX);
            nxt_r.wg = (r_ff.op != `LULK_OP_FIDX);
            if (r_ff.op == `LULK_OP_LL_W || r_ff.op == `LULK_OP_LL_D) begin
              nxt_r.link = 1'b1;
            end
            nxt_r.st = LULK_DONE;
          end
        end
      end
      LULK_DONE: begin
        nxt_r.st = LULK_IDLE;
      end
      LULK_FAIL: begin
        nxt_r.exc = 1'b1;
        nxt_r.st = LULK_DONE;
      end
      default: begin
        nxt_r.st = LULK_IDLE;
      end
    endcase
    nxt_r.bsy = (nxt_r.st != LULK_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
      r_ff.st <= LULK_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // memory address: whole aligned doubleword, lanes picked on return
  assign xlat_req = r_ff.xreq;
  assign virtual_addr = r_ff.va;
  assign mem_req = r_ff.mreq;
  assign mem_addr = {r_ff.pa[63:3], 3'h0};
  assign mem_attr = r_ff.attr;
  assign wb_gpr = r_ff.wg;
  assign wb_float_register = r_ff.wf;
  assign wb_sel = r_ff.sel;
  assign wb_data = r_ff.data;
  assign exc_valid = r_ff.exc;
  assign exc_code = r_ff.code;
  assign busy = r_ff.bsy;
  assign link_flag = r_ff.link;
  assign cond_ok = r_ff.ok;

  // assertion helpers from the raw request fields
  assign take = (r_ff.st == LULK_IDLE) && req_valid;
  assign ofs_ext = {{48{offset[15]}}, offset};
  assign ofs_low = 3'(base_val[2:0] + offset[2:0]);
  assign idx_low = 3'(base_val[2:0] + index_val[2:0]);

  a_addr_fault: assert property (@(posedge clk) disable iff (rst)
    (r_ff.st == LULK_IDLE && req_valid && !op_reserved && !watch_hit &&
     (req_op != `LULK_OP_FIDX || float_usable) && req_op != `LULK_OP_RIGHT
     && ((ea[2:0] & align_mask(req_op)) != 3'h0))
    |-> ##2 (exc_valid && exc_code == `LULK_EXC_ADDR))
    else $error("misaligned load did not fault");
  a_half_sign: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_HALF_S)
    |-> wb_data[63:16] == {48{wb_data[15]}})
    else $error("signed half not extended");
  a_half_zero: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_HALF_U) |-> wb_data[63:16] == 48'h0)
    else $error("unsigned half not zero extended");
  a_word_sign: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_LL_W)
    |-> wb_data[63:32] == {32{wb_data[31]}})
    else $error("linked word not extended");
  a_link_set: assert property (@(posedge clk) disable iff (rst)
    (r_ff.st == LULK_MEM && mem_ack && !mem_err && !cond_store &&
     (r_ff.op == `LULK_OP_LL_W || r_ff.op == `LULK_OP_LL_D))
    |=> link_flag && wb_gpr)
    else $error("link flag not set");
  a_cond_end: assert property (@(posedge clk) disable iff (rst)
    cond_store |=> (!link_flag || wb_gpr) && cond_ok == $past(link_flag))
    else $error("conditional store mishandled");
  a_float_dest: assert property (@(posedge clk) disable iff (rst)
    wb_float_register |-> r_ff.op == `LULK_OP_FIDX && !wb_gpr)
    else $error("float load wrote wrong file");
  a_xlat_first: assert property (@(posedge clk) disable iff (rst)
    mem_req |-> $past(r_ff.st) != LULK_IDLE && r_ff.st == LULK_MEM)
    else $error("memory access before translation");
  a_xreq_hold: assert property (@(posedge clk) disable iff (rst)
    (xlat_req && !xlat_ack) |=> (xlat_req && $stable(virtual_addr)))
    else $error("translation request dropped early");
  a_xreq_drop: assert property (@(posedge clk) disable iff (rst)
    (xlat_req && xlat_ack) |=> !xlat_req)
    else $error("translation request held past ack");
  a_mreq_hold: assert property (@(posedge clk) disable iff (rst)
    (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)))
    else $error("memory request dropped early");
  a_mreq_drop: assert property (@(posedge clk) disable iff (rst)
    (mem_req && mem_ack) |=> !mem_req)
    else $error("memory request held past ack");
  a_attr_kept: assert property (@(posedge clk) disable iff (rst)
    (xlat_req && xlat_ack && xlat_fault == `LULK_EXC_NONE)
    |=> (mem_req && mem_attr == $past(cacheability_attribute) &&
         mem_addr == ($past(phys_addr) & ~64'h7)))
    else $error("translation result not used");
  a_ea_index: assert property (@(posedge clk) disable iff (rst)
    (take && req_op == `LULK_OP_FIDX)
    |=> virtual_addr == $past(base_val) + $past(index_val))
    else $error("indexed address wrong");
  a_ea_offset: assert property (@(posedge clk) disable iff (rst)
    (take && req_op != `LULK_OP_FIDX)
    |=> virtual_addr == $past(base_val) + $past(ofs_ext))
    else $error("offset address wrong");
  a_cpu_unusable: assert property (@(posedge clk) disable iff (rst)
    (take && !op_reserved && req_op == `LULK_OP_FIDX && !float_usable)
    |-> ##2 (exc_valid && exc_code == `LULK_EXC_CPU))
    else $error("coprocessor unusable not raised");
  a_half_odd: assert property (@(posedge clk) disable iff (rst)
    (take && ofs_low[0] &&
     (req_op == `LULK_OP_HALF_S || req_op == `LULK_OP_HALF_U))
    |=> !xlat_req ##1 (exc_valid && !mem_req))
    else $error("odd half load reached memory");
  a_word_align: assert property (@(posedge clk) disable iff (rst)
    (take && !op_reserved && req_op == `LULK_OP_LL_W &&
     ofs_low[1:0] != 2'h0)
    |-> ##2 (exc_valid && exc_code == `LULK_EXC_ADDR))
    else $error("misaligned linked word not faulted");
  a_dbl_align: assert property (@(posedge clk) disable iff (rst)
    (take && !op_reserved && req_op == `LULK_OP_LL_D && ofs_low != 3'h0)
    |-> ##2 (exc_valid && exc_code == `LULK_EXC_ADDR))
    else $error("misaligned linked double not faulted");
  a_idx_align: assert property (@(posedge clk) disable iff (rst)
    (take && !op_reserved && float_usable &&
     req_op == `LULK_OP_FIDX && idx_low != 3'h0)
    |-> ##2 (exc_valid && exc_code == `LULK_EXC_ADDR))
    else $error("misaligned indexed load not faulted");
  a_dbl_whole: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_LL_D) |-> wb_data == $past(mem_data))
    else $error("linked double modified");
  a_float_whole: assert property (@(posedge clk) disable iff (rst)
    wb_float_register |-> wb_data == $past(mem_data))
    else $error("float double modified");
  a_right_whole: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_RIGHT &&
     (r_ff.va[2:0] ^ {3{r_ff.big}}) == 3'h0)
    |-> wb_data == $past(mem_data))
    else $error("right part full load wrong");
  a_right_keep: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.op == `LULK_OP_RIGHT &&
     (r_ff.va[2:0] ^ {3{r_ff.big}}) == 3'h7)
    |-> (wb_data[63:8] == r_ff.old[63:8] &&
         wb_data[7:0] == 8'($past(mem_data) >> 56)))
    else $error("right part lost kept bytes");
  a_half_lane: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr && r_ff.va[2:1] == 2'h0 &&
     (r_ff.op == `LULK_OP_HALF_S || r_ff.op == `LULK_OP_HALF_U))
    |-> wb_data[15:0] == (r_ff.big ? 16'($past(mem_data) >> 48)
                                   : 16'($past(mem_data))))
    else $error("half lane wrong");
  a_link_hold: assert property (@(posedge clk) disable iff (rst)
    (link_flag && !cond_store && !link_break) |=> link_flag)
    else $error("link flag lost without cause");
  a_wb_pulse: assert property (@(posedge clk) disable iff (rst)
    (wb_gpr || wb_float_register)
    |=> !(wb_gpr || wb_float_register || exc_valid))
    else $error("writeback longer than one cycle");
  a_exc_pulse: assert property (@(posedge clk) disable iff (rst)
    exc_valid |=> (!exc_valid && !wb_gpr && !wb_float_register))
    else $error("exception longer than one cycle");
  a_busy_hold: assert property (@(posedge clk) disable iff (rst)
    busy |=> $stable(virtual_addr))
    else $error("request taken while busy");
endmodule // lulk_unit
